/* File: core/ctfr_relay.sv */
`timescale 1ns/10ps
`default_nettype none

// Contract
// - One whole received reader block goes into one tunnel frame payload.
// - Block longer than the tunnel allows is handled as an RF-side error.
// - Oversize block is signalled by a tunnel frame with a wrong CRC.
// - Downlink frame may start while the reader block is still arriving.
// - Receive latency runs from last reader pause end to downlink end.
// - Transmit latency runs from uplink frame start to first RF modulation.
// - Empty uplink frame: transmit latency ends when ready for next block.
// - Each uplink payload goes to the reader as exactly one RF block; the code drops a payload that answers a request or wake-up.
// - RF sending may wait for the whole frame or start while it arrives.
// - Bad uplink CRC: store-and-forward never modulates; pipelined aborts.
// - Receive plus transmit latency within 210 us plus 15 us per byte.
// - Latency byte counts hold data bytes only, no framing bits.
// - Serialising time on the wire counts inside both latencies.
// - Request or wake-up is forwarded in a one-byte tunnel payload.
// - Request or wake-up exchange latency stays within 190 us.
// - Request in active state moves card to idle or halt, no reply.
// - Passive 212/424 timing is met by balancing processing and link rate.
// - Both parties keep processing delays small for transaction timing.
// - Corrupted or reserved-control frames keep the tunnel link running.
// - Session opens, closing any old one, by a Type A or F open frame.
// - Return-to-init frame sends the emulated card back to initialisation.
module ctfr_relay
	import ctfr_pkg::*;
#(
	parameter int BUDGET_BASE_CYCLES = BUDGET_BASE_CYC, // 210 us at core rate
	parameter int REQ_BUDGET_CYCLES  = REQ_BUDGET_CYC   // 190 us at core rate
)
(
	input  wire logic       core_clk,       // Core clock
	input  wire logic       sys_rst,        // Synchronous reset
	input  wire logic       open_req,       // Open a tunnel session
	input  wire logic       open_type_f,    // Announce Type F instead of A
	input  wire logic       pipeline_en,    // Uplink pipelined when high
	input  wire logic       rf_rx_start,    // Reader block begins
	input  wire logic       rf_rx_vld,      // Reader data byte strobe
	input  wire logic [7:0] rf_rx_byte,     // Reader data byte
	input  wire logic       rf_rx_short,    // Block is a short frame
	input  wire logic       rf_rx_end,      // End of last reader pause
	input  wire logic       rf_rx_err,      // RF-side error in block
	input  wire logic       ul_sof,         // Uplink frame start
	input  wire logic [7:0] ul_ctrl,        // Control byte field, with sof
	input  wire logic       ul_vld,         // Uplink payload byte strobe
	input  wire logic [7:0] ul_byte,        // Uplink payload byte
	input  wire logic       ul_eof,         // Uplink frame end
	input  wire logic       ul_crc_ok,      // Uplink CRC good, with eof
	input  wire logic       rf_tx_take,     // Modulator wants a byte
	output logic            dl_sof,         // Downlink frame start
	output logic [7:0]      dl_ctrl,        // Downlink control byte field
	output logic            dl_vld,         // Downlink payload byte strobe
	output logic [7:0]      dl_byte,        // Downlink payload byte
	output logic            dl_eof,         // Downlink frame end
	output logic            dl_bad_crc,     // Close frame with wrong CRC
	output logic            rf_tx_start,    // RF block begins
	output logic            rf_tx_vld,      // RF byte strobe
	output logic [7:0]      rf_tx_byte,     // RF byte
	output logic            rf_tx_end,      // RF block complete
	output logic            rf_tx_abort,    // Spoil the RF block
	output logic            rf_rx_ready,    // Ready for next reader block
	output logic            session_active, // Tunnel session open
	output logic [1:0]      card_state,     // Emulated card state
	output logic            budget_miss     // Latency budget exceeded
);

	ctfr_state_t st_ff;
	ctfr_state_t nxt_st;

	logic              mem_we;
	logic [BUF_AW-1:0] mem_waddr;
	logic [BUF_AW-1:0] mem_raddr;
	logic [7:0]        mem_rdata_ff;

	// Payload buffer serves both store-and-forward and pipelined sending
	ctfr_buf u_buf (
		.core_clk (core_clk),
		.we       (mem_we),
		.waddr    (mem_waddr),
		.wdata    (ul_byte),
		.raddr    (mem_raddr),
		.rdata_ff (mem_rdata_ff)
	);

	logic [LAT_W-1:0] limit;
	logic [9:0]       byte_sum;
	logic             lat_stop;
	logic             is_request;

	// Next-state logic for the whole relay
	always_comb
	begin
		nxt_st      = st_ff;
		mem_we      = 1'b0;
		mem_waddr   = st_ff.wr_ptr[BUF_AW-1:0];
		mem_raddr   = st_ff.rd_ptr[BUF_AW-1:0];
		lat_stop    = 1'b0;
		byte_sum    = {1'b0, st_ff.rx_bytes} + {1'b0, st_ff.wr_ptr};
		is_request  = rf_rx_short && (rf_rx_byte == CMD_REQ || rf_rx_byte == CMD_WAKE);
		limit       = st_ff.req_mode ? LAT_W'(REQ_BUDGET_CYCLES)
			: LAT_W'(BUDGET_BASE_CYCLES) + LAT_W'(PER_BYTE_CYC * int'(byte_sum));

		// Pulses last one cycle
		nxt_st.dl_sof      = 1'b0;
		nxt_st.dl_vld      = 1'b0;
		nxt_st.dl_eof      = 1'b0;
		nxt_st.dl_bad_crc  = 1'b0;
		nxt_st.tx_start    = 1'b0;
		nxt_st.tx_vld      = 1'b0;
		nxt_st.tx_end      = 1'b0;
		nxt_st.tx_abort    = 1'b0;
		nxt_st.budget_miss = 1'b0;

		// Session open frame: control byte, then close next cycle
		if (st_ff.open_eof)
		begin
			nxt_st.dl_eof   = 1'b1;
			nxt_st.open_eof = 1'b0;
		end
		else if (open_req && !st_ff.rx_in)
		begin
			nxt_st.session  = 1'b1;
			nxt_st.dl_sof   = 1'b1;
			nxt_st.dl_ctrl  = open_type_f ? CTRL_OPEN_F : CTRL_OPEN_A;
			nxt_st.open_eof = 1'b1;
			nxt_st.card     = CARD_IDLE;
			nxt_st.req_mode = 1'b0;
			nxt_st.lat      = LAT_IDLE;
		end

		// Reader block opens a downlink frame at once, pipelined
		if (st_ff.session && rf_rx_start && !st_ff.open_eof)
		begin
			nxt_st.rx_in   = 1'b1;
			nxt_st.rx_cnt  = CNT_ZERO;
			nxt_st.rx_over = 1'b0;
			nxt_st.dl_sof  = 1'b1;
			nxt_st.dl_ctrl = CTRL_DATA_A;
		end
		if (st_ff.rx_in && rf_rx_vld)
		begin
			if (st_ff.rx_cnt < MAX_PAYLOAD_LEN)
			begin
				nxt_st.dl_vld  = 1'b1;
				nxt_st.dl_byte = rf_rx_byte;
				nxt_st.rx_cnt  = st_ff.rx_cnt + 9'h001;
			end
			else
			begin
				nxt_st.rx_over = 1'b1;
			end
			// Request or wake-up in active state drops the card back
			if (is_request && st_ff.rx_cnt == CNT_ZERO)
			begin
				nxt_st.req_mode = 1'b1;
				if (st_ff.card == CARD_HALT && rf_rx_byte == CMD_WAKE)
				begin
					nxt_st.from_halt = 1'b1;
				end
				if (st_ff.card == CARD_ACTIVE)
				begin
					nxt_st.card = st_ff.from_halt ? CARD_HALT : CARD_IDLE;
				end
			end
		end
		if (st_ff.rx_in && rf_rx_end)
		begin
			nxt_st.rx_in      = 1'b0;
			nxt_st.dl_eof     = 1'b1;
			nxt_st.dl_bad_crc = st_ff.rx_over || rf_rx_err
				|| (st_ff.rx_cnt == MAX_PAYLOAD_LEN && rf_rx_vld);
			nxt_st.rx_bytes   = st_ff.rx_cnt;
			nxt_st.rx_ready   = 1'b0;
			nxt_st.lat        = LAT_RX;
			nxt_st.lat_cnt    = '0;
		end

		// Uplink frame classification; bad frames leave the session up
		if (st_ff.session && ul_sof)
		begin
			nxt_st.wr_ptr  = CNT_ZERO;
			nxt_st.rd_ptr  = CNT_ZERO;
			nxt_st.ul_done = 1'b0;
			if (ul_ctrl == CTRL_DATA_A)
			begin
				nxt_st.ul_kind = UL_DATA;
			end
			else if (ul_ctrl == CTRL_RETURN_INIT)
			begin
				nxt_st.ul_kind = UL_INIT;
			end
			else
			begin
				nxt_st.ul_kind = UL_IGNORE;
			end
			if (st_ff.lat == LAT_WAIT)
			begin
				nxt_st.lat = LAT_TX;
			end
		end
		if (st_ff.ul_kind == UL_DATA && ul_vld && st_ff.wr_ptr < MAX_PAYLOAD_LEN)
		begin
			mem_we        = 1'b1;
			nxt_st.wr_ptr = st_ff.wr_ptr + 9'h001;
			if (pipeline_en && !st_ff.tx_play && !st_ff.req_mode && st_ff.wr_ptr == CNT_ZERO)
			begin
				nxt_st.tx_play  = 1'b1;
				nxt_st.tx_start = 1'b1;
			end
		end
		if (st_ff.ul_kind != UL_NONE && ul_eof)
		begin
			nxt_st.ul_kind = UL_NONE;
			nxt_st.ul_done = 1'b1;
			if (!ul_crc_ok)
			begin
				// Corrupted frame: drop it, keep the tunnel link running
				if (st_ff.tx_play)
				begin
					nxt_st.tx_play  = 1'b0;
					nxt_st.tx_abort = 1'b1;
				end
				nxt_st.rx_ready = 1'b1;
				nxt_st.lat      = LAT_IDLE;
			end
			else if (st_ff.ul_kind == UL_INIT)
			begin
				nxt_st.card     = st_ff.from_halt ? CARD_HALT : CARD_IDLE;
				nxt_st.req_mode = 1'b0;
				nxt_st.rx_ready = 1'b1;
				lat_stop        = (st_ff.lat == LAT_TX);
			end
			else if (st_ff.ul_kind == UL_DATA)
			begin
				if (st_ff.req_mode || st_ff.wr_ptr == CNT_ZERO && !(ul_vld))
				begin
					// No reply to a request; empty frame frees the receiver
					nxt_st.req_mode = 1'b0;
					nxt_st.rx_ready = 1'b1;
					lat_stop        = (st_ff.lat == LAT_TX);
				end
				else
				begin
					nxt_st.card = CARD_ACTIVE;
					if (!pipeline_en)
					begin
						nxt_st.tx_play  = 1'b1;
						nxt_st.tx_start = 1'b1;
					end
				end
			end
			else
			begin
				// Reserved control value: dropped, receiver keeps waiting for the answer
			end
		end

		// RF playout: one byte per take, whole payload as one block
		if (st_ff.tx_play && !nxt_st.tx_abort && !st_ff.tx_start)
		begin
			if (rf_tx_take && !st_ff.tx_vld && st_ff.rd_ptr < st_ff.wr_ptr)
			begin
				nxt_st.rd_ptr = st_ff.rd_ptr + 9'h001;
				nxt_st.tx_vld = 1'b1;
				lat_stop      = (st_ff.rd_ptr == CNT_ZERO) && (st_ff.lat == LAT_TX);
			end
			else if (st_ff.ul_done && st_ff.rd_ptr == st_ff.wr_ptr && !st_ff.tx_vld)
			begin
				nxt_st.tx_play  = 1'b0;
				nxt_st.tx_end   = 1'b1;
				nxt_st.rx_ready = 1'b1;
			end
		end

		// Latency counter covers both wire serialisations, not the far end
		case (st_ff.lat)
			LAT_RX:
			begin
				nxt_st.lat_cnt = st_ff.lat_cnt + LAT_W'(1);
				if (st_ff.dl_eof)
				begin
					nxt_st.lat = LAT_WAIT;
				end
			end
			LAT_TX:
			begin
				nxt_st.lat_cnt = st_ff.lat_cnt + LAT_W'(1);
			end
			LAT_IDLE, LAT_WAIT:
			begin
				// Count left alone, so a block end can still clear it
			end
			default:
			begin
				nxt_st.lat = LAT_IDLE;
			end
		endcase
		if (lat_stop)
		begin
			nxt_st.lat         = LAT_IDLE;
			nxt_st.budget_miss = (st_ff.lat_cnt > limit);
		end
	end

	// State register
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st_ff <= ST_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state flops, except rf_tx_byte from the buffer read register
	assign dl_sof         = st_ff.dl_sof;
	assign dl_ctrl        = st_ff.dl_ctrl;
	assign dl_vld         = st_ff.dl_vld;
	assign dl_byte        = st_ff.dl_byte;
	assign dl_eof         = st_ff.dl_eof;
	assign dl_bad_crc     = st_ff.dl_bad_crc;
	assign rf_tx_start    = st_ff.tx_start;
	assign rf_tx_vld      = st_ff.tx_vld;
	assign rf_tx_byte     = mem_rdata_ff;
	assign rf_tx_end      = st_ff.tx_end;
	assign rf_tx_abort    = st_ff.tx_abort;
	assign rf_rx_ready    = st_ff.rx_ready;
	assign session_active = st_ff.session;
	assign card_state     = st_ff.card;
	assign budget_miss    = st_ff.budget_miss;

endmodule
`default_nettype wire

/* File: core/ctfr_pkg.sv */
package ctfr_pkg;

	// Core clock rate and latency budget figures
	localparam int CLK_MHZ         = 200;
	localparam int BUDGET_BASE_US  = 210;
	localparam int PER_BYTE_US     = 15;
	localparam int REQ_BUDGET_US   = 190;
	localparam int PER_BYTE_CYC    = PER_BYTE_US * CLK_MHZ;
	localparam int BUDGET_BASE_CYC = BUDGET_BASE_US * CLK_MHZ;
	localparam int REQ_BUDGET_CYC  = REQ_BUDGET_US * CLK_MHZ;
	localparam int LAT_W           = 22;

	// Payload buffer geometry and the largest payload the tunnel carries
	localparam int         BUF_AW          = 8;
	localparam logic [8:0] MAX_PAYLOAD_LEN = 9'h0FF;
	localparam logic [8:0] CNT_ZERO        = 9'h000;

	// Control byte field values of tunnel frames
	localparam logic [7:0] CTRL_DATA_A      = 8'h00;
	localparam logic [7:0] CTRL_OPEN_A      = 8'h81;
	localparam logic [7:0] CTRL_OPEN_F      = 8'h82;
	localparam logic [7:0] CTRL_RETURN_INIT = 8'h10;

	// Reader request and wake-up short frames
	localparam logic [7:0] CMD_REQ  = 8'h26;
	localparam logic [7:0] CMD_WAKE = 8'h52;

	typedef enum logic [1:0] {CARD_OFF, CARD_IDLE, CARD_ACTIVE, CARD_HALT} ctfr_card_t;
	typedef enum logic [1:0] {LAT_IDLE, LAT_RX, LAT_WAIT, LAT_TX} ctfr_lat_t;
	typedef enum logic [1:0] {UL_NONE, UL_DATA, UL_INIT, UL_IGNORE} ctfr_ul_t;

	typedef struct packed {
		logic             session;
		logic             from_halt;
		ctfr_card_t       card;
		logic             rx_in;
		logic [8:0]       rx_cnt;
		logic             rx_over;
		logic             open_eof;
		logic             dl_sof;
		logic [7:0]       dl_ctrl;
		logic             dl_vld;
		logic [7:0]       dl_byte;
		logic             dl_eof;
		logic             dl_bad_crc;
		ctfr_ul_t         ul_kind;
		logic             ul_done;
		logic             req_mode;
		logic [8:0]       wr_ptr;
		logic [8:0]       rd_ptr;
		logic             tx_play;
		logic             tx_start;
		logic             tx_vld;
		logic             tx_end;
		logic             tx_abort;
		logic             rx_ready;
		ctfr_lat_t        lat;
		logic [LAT_W-1:0] lat_cnt;
		logic [8:0]       rx_bytes;
		logic             budget_miss;
	} ctfr_state_t;

	localparam ctfr_state_t ST_RESET = '0;

endpackage

/* File: core/ctfr_buf.sv */
`timescale 1ns/10ps
`default_nettype none

// Payload store for uplink frames; read data comes out of a register
module ctfr_buf
	import ctfr_pkg::*;
(
	input  wire logic              core_clk,  // Core clock
	input  wire logic              we,        // Write strobe
	input  wire logic [BUF_AW-1:0] waddr,     // Write address
	input  wire logic [7:0]        wdata,     // Write byte
	input  wire logic [BUF_AW-1:0] raddr,     // Read address
	output var  logic [7:0]        rdata_ff   // Registered read byte
);

	logic [7:0] mem [0:(1<<BUF_AW)-1];

	// No reset on the array; contents are only read after being written
	always_ff @(posedge core_clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata_ff <= mem[raddr];
	end

endmodule
`default_nettype wire

/* File: tb/ctfr_se_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Secure element side; frames are sent on demand by the bench
module ctfr_se_model
	import ctfr_pkg::*;
(
	input  wire logic       core_clk,  // Core clock
	output var  logic       ul_sof,    // Frame start
	output var  logic [7:0] ul_ctrl,   // Control byte field
	output var  logic       ul_vld,    // Payload strobe
	output var  logic [7:0] ul_byte,   // Payload byte
	output var  logic       ul_eof,    // Frame end
	output var  logic       ul_crc_ok  // CRC good, with eof
);
	// Quiet line at time zero
	initial
	begin
		{ul_sof, ul_vld, ul_eof, ul_crc_ok} = 4'h0;
		{ul_ctrl, ul_byte}                  = 16'h0000;
	end

	// Downlink frames are never parsed, so a corrupted one is simply dropped
	// One outgoing block in exactly one frame; n of zero omits the payload
	task automatic send(input logic [7:0] ctrl, input int n, input logic [7:0] b0,
		input logic ok);
		int i;
		@(negedge core_clk);
		ul_sof  = 1'h1;
		ul_ctrl = ctrl;
		@(negedge core_clk);
		ul_sof  = 1'h0;
		ul_ctrl = ~ctrl; // Field is released, so it must not keep its value
		for (i = 0; i < n; i++)
		begin
			ul_vld  = 1'h1;
			ul_byte = b0 + 8'(i);
			@(negedge core_clk);
		end
		ul_vld    = 1'h0;
		ul_byte   = ~ul_byte;
		ul_eof    = 1'h1;
		ul_crc_ok = ok; // A bad CRC only when a scenario asks for it
		@(negedge core_clk);
		ul_eof    = 1'h0;
		ul_crc_ok = ~ok;
	endtask
endmodule

`default_nettype wire

/* File: tb/ctfr_relay_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module ctfr_relay_sva
	import ctfr_pkg::*;
(
	input wire logic       core_clk,       // Core clock
	input wire logic       sys_rst,        // Sync reset
	input wire logic       open_req,       // Open request
	input wire logic       open_type_f,    // Type F select
	input wire logic       pipeline_en,    // Pipelined uplink
	input wire logic       rf_rx_start,    // Reader block start
	input wire logic       rf_rx_vld,      // Reader byte strobe
	input wire logic [7:0] rf_rx_byte,     // Reader byte
	input wire logic       rf_rx_end,      // Reader block end
	input wire logic       rf_rx_err,      // Reader block error
	input wire logic       ul_eof,         // Uplink end
	input wire logic       ul_crc_ok,      // Uplink CRC good
	input wire logic       rf_tx_take,     // Modulator pull
	input wire logic       dl_sof,         // Downlink start
	input wire logic [7:0] dl_ctrl,        // Downlink control
	input wire logic       dl_vld,         // Downlink strobe
	input wire logic [7:0] dl_byte,        // Downlink byte
	input wire logic       dl_eof,         // Downlink end
	input wire logic       dl_bad_crc,     // Wrong CRC
	input wire logic       rf_tx_start,    // RF block start
	input wire logic       rf_tx_vld,      // RF strobe
	input wire logic       rf_tx_end,      // RF block end
	input wire logic       rf_tx_abort,    // RF spoil
	input wire logic       rf_rx_ready,    // Ready for reader
	input wire logic       session_active  // Session open
);
	typedef struct packed {
		logic       blk; // Reader block in flight
		logic [8:0] cnt; // Bytes so far, saturates at 256
	} ctfr_chk_t;
	ctfr_chk_t st_ff;
	ctfr_chk_t nxt_st;

	// Mirror of the reader block so overlength can be judged
	always_comb
	begin
		nxt_st = st_ff;
		if (rf_rx_start)
			nxt_st = '{blk: 1'h1, cnt: 9'h000};
		if (rf_rx_vld && !st_ff.cnt[8])
			nxt_st.cnt = st_ff.cnt + 9'h001;
		if (rf_rx_end)
			nxt_st.blk = 1'h0;
	end
	always_ff @(posedge core_clk)
		st_ff <= sys_rst ? '0 : nxt_st;

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_open_ans;
		open_req && !st_ff.blk && !rf_rx_start |=>
			dl_sof && dl_ctrl == ($past(open_type_f) ? CTRL_OPEN_F : CTRL_OPEN_A);
	endproperty
	a_open_ans: assert property (p_open_ans) else $error("open frame wrong");
	property p_open_eof;
		dl_sof && dl_ctrl[7] |=> dl_eof;
	endproperty
	a_open_eof: assert property (p_open_eof) else $error("open frame not closed");
	property p_sess_set;
		$rose(session_active) |-> dl_sof && dl_ctrl[7];
	endproperty
	a_sess_set: assert property (p_sess_set) else $error("session without open");
	property p_rx_sof;
		rf_rx_start && session_active |=> dl_sof && dl_ctrl == CTRL_DATA_A;
	endproperty
	a_rx_sof: assert property (p_rx_sof) else $error("block frame not opened");
	property p_rx_byte;
		rf_rx_vld && st_ff.blk && session_active && st_ff.cnt < 9'h0FF
			|=> dl_vld && dl_byte == $past(rf_rx_byte);
	endproperty
	a_rx_byte: assert property (p_rx_byte) else $error("byte not relayed");
	property p_rx_over;
		rf_rx_vld && st_ff.blk && st_ff.cnt >= 9'h0FF |=> !dl_vld;
	endproperty
	a_rx_over: assert property (p_rx_over) else $error("byte past limit relayed");
	property p_rx_bad;
		rf_rx_end && st_ff.blk && session_active && (rf_rx_err || st_ff.cnt[8])
			|=> dl_eof && dl_bad_crc;
	endproperty
	a_rx_bad: assert property (p_rx_bad) else $error("error not signalled");
	property p_rx_good;
		rf_rx_end && st_ff.blk && session_active && !rf_rx_err && !st_ff.cnt[8]
			|=> dl_eof && !dl_bad_crc;
	endproperty
	a_rx_good: assert property (p_rx_good) else $error("good block spoiled");
	property p_store_bad;
		!pipeline_en && ul_eof && !ul_crc_ok && session_active
			|=> (!rf_tx_start && !rf_tx_vld) [*8];
	endproperty
	a_store_bad: assert property (p_store_bad) else $error("bad frame modulated");
	property p_tx_pull;
		rf_tx_vld |-> $past(rf_tx_take);
	endproperty
	a_tx_pull: assert property (p_tx_pull) else $error("byte not pulled");
	property p_ready_drop;
		rf_rx_end && session_active |=> !rf_rx_ready;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready kept");

	c_bad_frame: cover property (dl_eof && dl_bad_crc);
	c_tx_end: cover property (rf_tx_end);
	c_abort: cover property (rf_tx_abort);
endmodule

bind ctfr_relay ctfr_relay_sva u_sva (.core_clk(core_clk), .sys_rst(sys_rst),
	.open_req(open_req), .open_type_f(open_type_f), .pipeline_en(pipeline_en),
	.rf_rx_start(rf_rx_start), .rf_rx_vld(rf_rx_vld), .rf_rx_byte(rf_rx_byte),
	.rf_rx_end(rf_rx_end), .rf_rx_err(rf_rx_err), .ul_eof(ul_eof), .ul_crc_ok(ul_crc_ok),
	.rf_tx_take(rf_tx_take), .dl_sof(dl_sof), .dl_ctrl(dl_ctrl), .dl_vld(dl_vld),
	.dl_byte(dl_byte), .dl_eof(dl_eof), .dl_bad_crc(dl_bad_crc), .rf_tx_start(rf_tx_start),
	.rf_tx_vld(rf_tx_vld), .rf_tx_end(rf_tx_end), .rf_tx_abort(rf_tx_abort),
	.rf_rx_ready(rf_rx_ready), .session_active(session_active));

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import ctfr_pkg::*;
();
	logic       core_clk, sys_rst, open_req, open_type_f, pipeline_en, rf_tx_take;
	logic       rf_rx_start, rf_rx_vld, rf_rx_short, rf_rx_end, rf_rx_err;
	logic [7:0] rf_rx_byte, ul_ctrl, ul_byte, dl_ctrl, dl_byte, rf_tx_byte, ctl_last;
	logic       ul_sof, ul_vld, ul_eof, ul_crc_ok, dl_sof, dl_vld, dl_eof, dl_bad_crc;
	logic       rf_tx_start, rf_tx_vld, rf_tx_end, rf_tx_abort, rf_rx_ready;
	logic       session_active, budget_miss, take_hold;
	logic [1:0] card_state;
	logic [7:0] dl_q[$], tx_q[$];
	int         n_mismatch, checks_done, n_cyc, n_sof, n_bad, n_ts, n_te, n_ab, n_miss;

	initial
	begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Small budgets keep the late-answer case short
	ctfr_relay #(.BUDGET_BASE_CYCLES(400), .REQ_BUDGET_CYCLES(300)) dut (.*);
	ctfr_se_model se (.core_clk(core_clk), .ul_sof(ul_sof), .ul_ctrl(ul_ctrl),
		.ul_vld(ul_vld), .ul_byte(ul_byte), .ul_eof(ul_eof), .ul_crc_ok(ul_crc_ok));

	// Modulator pulls one byte, then lets a cycle pass; take_hold stalls it
	always @(negedge core_clk)
		rf_tx_take <= !rf_tx_vld && !take_hold;

	// Output events tallied; a hang is cut off at the ceiling
	always @(posedge core_clk)
	begin
		n_cyc++;
		if (dl_sof)
			ctl_last = dl_ctrl;
		n_sof  += dl_sof;
		n_bad  += dl_bad_crc;
		n_ts   += rf_tx_start;
		n_te   += rf_tx_end;
		n_ab   += rf_tx_abort;
		n_miss += budget_miss;
		if (dl_vld)
			dl_q.push_back(dl_byte);
		if (rf_tx_vld)
			tx_q.push_back(rf_tx_byte);
		if (n_cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic clr();
		{n_sof, n_bad, n_ts, n_te, n_ab, n_miss} = '0;
		dl_q.delete();
		tx_q.delete();
	endtask

	task automatic open(input logic f);
		@(negedge core_clk);
		open_req    = 1'h1;
		open_type_f = f;
		@(negedge core_clk);
		open_req = 1'h0;
		repeat (3) @(negedge core_clk);
	endtask

	task automatic rx_block(input int n, input logic [7:0] b0, input logic sh, input logic e);
		int i;
		@(negedge core_clk);
		rf_rx_start = 1'h1;
		@(negedge core_clk);
		rf_rx_start = 1'h0;
		for (i = 0; i < n; i++)
		begin
			{rf_rx_vld, rf_rx_short, rf_rx_byte} = {1'h1, sh, b0 + 8'(i)};
			@(negedge core_clk);
		end
		{rf_rx_vld, rf_rx_byte, rf_rx_end, rf_rx_err} = {1'h0, ~rf_rx_byte, 1'h1, e};
		@(negedge core_clk);
		{rf_rx_end, rf_rx_err} = 2'h0;
		repeat (3) @(negedge core_clk);
	endtask

	// Reader block, an ignored reserved frame, then the answer frame
	task automatic ul_round(input logic [7:0] rb, input logic [7:0] ctrl, input int n,
		input logic ok);
		int i;
		clr();
		rx_block(1, rb, rb == CMD_REQ || rb == CMD_WAKE, 1'h0);
		se.send(8'h55, 2, 8'h77, 1'h1);
		se.send(ctrl, n, 8'hC0, ok);
		for (i = 0; i < 80 && rf_rx_ready !== 1'h1; i++)
			@(negedge core_clk);
		// Let the monitor count pulses launched with ready
		@(negedge core_clk);
		cmp("ready", 16'h0001, 16'(rf_rx_ready));
		cmp("miss", 16'h0000, 16'(n_miss));
	endtask

	task automatic t_open();
		rx_block(2, 8'h11, 1'h0, 1'h0);
		cmp("sof off", 16'h0000, 16'(n_sof));
		open(1'h1);
		cmp("ctrl F", 16'(CTRL_OPEN_F), 16'(ctl_last));
		open(1'h0);
		cmp("ctrl A", 16'(CTRL_OPEN_A), 16'(ctl_last));
		cmp("session", 16'h0001, 16'(session_active));
		cmp("card", 16'(CARD_IDLE), 16'(card_state));
		$display("t_open done");
	endtask

	task automatic t_rx();
		int n;
		for (n = 255; n <= 256; n++)
		begin
			clr();
			rx_block(n, 8'h00, 1'h0, 1'h0);
			cmp("dl count", 16'(n > 255 ? 255 : n), 16'(dl_q.size()));
			cmp("dl last", 16'h00FE, 16'(dl_q[254]));
			cmp("bad crc", 16'(n > 255), 16'(n_bad));
		end
		clr();
		rx_block(1, 8'h5A, 1'h0, 1'h1);
		cmp("err crc", 16'h0001, 16'(n_bad));
		$display("t_rx done");
	endtask

	task automatic t_ul();
		int p;
		int i;
		for (p = 0; p < 2; p++)
		begin
			pipeline_en = p[0];
			ul_round(8'h01, CTRL_DATA_A, 4, 1'h1);
			cmp("tx count", 16'h0004, 16'(tx_q.size()));
			for (i = 0; i < tx_q.size(); i++)
				cmp("tx byte", 16'(8'hC0 + i), 16'(tx_q[i]));
			cmp("tx blocks", 16'h0101, 16'({n_ts[7:0], n_te[7:0]}));
			ul_round(8'h02, CTRL_DATA_A, 3, 1'h0);
			cmp("bad start", 16'(p), 16'(n_ts));
			cmp("abort", 16'(p), 16'(n_ab));
		end
		$display("t_ul done");
	endtask

	task automatic t_req();
		int k;
		for (k = 0; k < 2; k++)
		begin
			ul_round(k ? CMD_WAKE : CMD_REQ, CTRL_RETURN_INIT, 0, 1'h1);
			cmp("req len", 16'h0001, 16'(dl_q.size()));
			cmp("req byte", 16'(k ? CMD_WAKE : CMD_REQ), 16'(dl_q[0]));
			cmp("no reply", 16'h0000, 16'(n_ts + tx_q.size()));
			cmp("card", 16'(CARD_IDLE), 16'(card_state));
		end
		$display("t_req done");
	endtask

	task automatic t_budget();
		int i;
		clr();
		pipeline_en = 1'h0;
		rx_block(0, 8'h00, 1'h0, 1'h0);
		// Far-end wait is not counted, so stall the modulator instead
		take_hold = 1'h1;
		se.send(CTRL_DATA_A, 1, 8'hA5, 1'h1);
		repeat (3500) @(negedge core_clk); // Beyond 400 plus 3000 for one byte
		take_hold = 1'h0;
		for (i = 0; i < 40 && rf_rx_ready !== 1'h1; i++)
			@(negedge core_clk);
		@(negedge core_clk);
		cmp("late miss", 16'h0001, 16'(n_miss));
		$display("t_budget done");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		{sys_rst, open_req, open_type_f, pipeline_en, take_hold} = 5'h10;
		{rf_rx_start, rf_rx_vld, rf_rx_short, rf_rx_end, rf_rx_err, rf_rx_byte} = '0;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'h0;
		t_open();
		t_rx();
		t_ul();
		t_req();
		t_budget();
		tally_and_finish();
	end
endmodule

`default_nettype wire
